//--- design/sbap_map.vh
// What this block does
// - Command byte picks register, frame or SRAM access
// - Register read returns data in second byte
// - Mode 0: sample rising, shift falling, MSB first
// - Register write stores second MOSI byte, in CTRL1 only
// - Frame buffer holds 128 bytes
// - Frame read sends length then payload bytes
// - Frame read appends quality, energy, status bytes
// - Aborted frame read restarts at length byte
// - Frame write stores length then payload in order
// - Length max 127; read n+5, write n+2
// - Each in-range frame data byte advances address counter
// - Frame-mode access violation raises under-run interrupt
// - Received frame overwrites stored transmit data
// - SRAM byte two is address; buffer or security
// - SRAM read data starts at third byte
// - SRAM write data from third byte, successive addresses
// - Each SRAM data byte increments address
// - SRAM violations raise no under-run interrupt
// - First MISO byte is status echo, reset zero
// - Echo select: zero, state, signal strength, pending
// - Echoing pending interrupts clears nothing
`ifndef SBAP_MAP_VH
`define SBAP_MAP_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SBAP_REG_STATE     6'h01
`define SBAP_REG_CTRL1     6'h04
`define SBAP_REG_RSSI      6'h06
`define SBAP_REG_IRQ       6'h0F
`define SBAP_CTRL1_RST     8'h20
`define SBAP_ECHO_HI       3
`define SBAP_ECHO_LO       2
`define SBAP_ECHO_ZERO     2'h0
`define SBAP_ECHO_STATE    2'h1
`define SBAP_ECHO_RSSI     2'h2
`define SBAP_ECHO_IRQ      2'h3

// ----------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------
`define SBAP_CMD_REG_BIT   7
`define SBAP_CMD_WR_BIT    6
`define SBAP_CMD_MODE_HI   7
`define SBAP_CMD_MODE_LO   5
`define SBAP_CMD_SRAM_RD   3'h0
`define SBAP_CMD_FB_RD     3'h1
`define SBAP_CMD_SRAM_WR   3'h2
`define SBAP_CMD_FB_WR     3'h3

// ----------------------------------------------------------------
// Buffer and address spaces
// ----------------------------------------------------------------
`define SBAP_FBUF_DEPTH    128
`define SBAP_FBUF_LAST     8'h7F
`define SBAP_SEC_LO        8'h82
`define SBAP_SEC_HI        8'h94
`define SBAP_LEN_ADDR      7'h00
`define SBAP_TAIL_LEN      8'h03
`define SBAP_TAIL_LQI      8'h00
`define SBAP_TAIL_ED       8'h01
`define SBAP_TAIL_STAT     8'h02
`define SBAP_FILL          8'h00
`define SBAP_BIT_LAST      3'h7
`define SBAP_BIT_FIRST     3'h0

// ----------------------------------------------------------------
// Transfer states
// ----------------------------------------------------------------
`define SBAP_ST_IDLE       3'h0
`define SBAP_ST_CMD        3'h1
`define SBAP_ST_REGRD      3'h2
`define SBAP_ST_REGWR      3'h3
`define SBAP_ST_FBRD       3'h4
`define SBAP_ST_FBWR       3'h5
`define SBAP_ST_SRADR      3'h6
`define SBAP_ST_SRDAT      3'h7

`endif

//--- design/sbap_fbuf.v
`timescale 1ns/100ps
`include "sbap_map.vh"
module sbap_fbuf (
    // Clock
    input  wire       clk,
    // Serial side write port
    input  wire       spiWrEn,
    input  wire [6:0] spiWrIdx,
    input  wire [7:0] spiWrData,
    // Radio side write port
    input  wire       rxWrEn,
    input  wire [6:0] rxWrIdx,
    input  wire [7:0] rxWrData,
    // Read port
    input  wire [6:0] rdIdx,
    output wire [7:0] rdData,
    output wire [6:0] frameLen
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [7:0] mem [0:`SBAP_FBUF_DEPTH-1];

    // Radio wins a clash: a fresh frame must never be lost
    always @(posedge clk) begin
        if (rxWrEn) begin
            mem[rxWrIdx] <= rxWrData;
        end else if (spiWrEn) begin
            mem[spiWrIdx] <= spiWrData;
        end
    end

    // Read paths, length byte always visible
    assign rdData   = mem[rdIdx];
    assign frameLen = mem[`SBAP_LEN_ADDR][6:0];

endmodule

//--- design/sbap_core.v
`timescale 1ns/100ps
`include "sbap_map.vh"
module sbap_core (
    // System
    input  wire       clk,
    input  wire       rst,
    // Serial pins
    input  wire       sclk,
    input  wire       selN,
    input  wire       mosi,
    output reg        miso_r,
    output reg        misoOe_r,
    // Radio status inputs
    input  wire [7:0] radioState,
    input  wire [7:0] signalStrength,
    input  wire [7:0] irqPending,
    input  wire [7:0] lqiValue,
    input  wire [7:0] edValue,
    input  wire [7:0] rxStatus,
    // Radio receive write port
    input  wire       rxWrEn,
    input  wire [6:0] rxWrIdx,
    input  wire [7:0] rxWrData,
    // Security space port
    input  wire [7:0] secRdData,
    output reg  [7:0] secAddr_r,
    output reg  [7:0] secWrData_r,
    output reg        secWrEn_r,
    // Control and events
    output reg  [7:0] trxCtrlOne_r,
    output reg        bufferViolationIrq_r
);

    // ----------------------------------------------------------------
    // Address space decode
    // ----------------------------------------------------------------
    // Frame buffer window
    function inFbuf;
        input [7:0] a;
        begin
            inFbuf = (a <= `SBAP_FBUF_LAST);
        end
    endfunction

    // Security module window
    function inSec;
        input [7:0] a;
        begin
            inSec = (a >= `SBAP_SEC_LO) && (a <= `SBAP_SEC_HI);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg  [2:0] sclkSh_r;
    reg  [2:0] selSh_r;
    reg  [1:0] mosiSh_r;

    // Two stages before use; third stage only for edge finding
    always @(posedge clk) begin
        if (rst) begin
            sclkSh_r <= 3'h0;
            selSh_r  <= 3'h7;
            mosiSh_r <= 2'h0;
        end else begin
            sclkSh_r <= {sclkSh_r[1:0], sclk};
            selSh_r  <= {selSh_r[1:0], selN};
            mosiSh_r <= {mosiSh_r[0], mosi};
        end
    end

    wire       sclkRise = sclkSh_r[1] & ~sclkSh_r[2];
    wire       sclkFall = ~sclkSh_r[1] & sclkSh_r[2];
    wire       selAct   = ~selSh_r[1];
    wire       selStart = selAct & selSh_r[2];
    wire       mosiS    = mosiSh_r[1];

    // ----------------------------------------------------------------
    // Transfer state
    // ----------------------------------------------------------------
    reg  [2:0] state_r;
    reg  [2:0] bitCnt_r;
    reg  [6:0] rxSh_r;
    reg  [7:0] txSh_r;
    reg  [5:0] regAddr_r;
    reg  [7:0] addr_r;
    reg        sramWr_r;
    reg        spiWrEn_r;
    reg  [6:0] spiWrIdx_r;
    reg  [7:0] spiWrData_r;

    wire [7:0] rxByte = {rxSh_r, mosiS};
    wire [7:0] fbRdData;
    wire [6:0] frameLen;
    wire [7:0] lenByte = {1'b0, frameLen};
    wire [7:0] tailEnd = lenByte + `SBAP_TAIL_LEN;
    wire [7:0] tailPos = addr_r - lenByte - 8'h01;

    // ----------------------------------------------------------------
    // Shared frame buffer
    // ----------------------------------------------------------------
    sbap_fbuf u_fbuf (
        .clk       (clk),
        .spiWrEn   (spiWrEn_r),
        .spiWrIdx  (spiWrIdx_r),
        .spiWrData (spiWrData_r),
        .rxWrEn    (rxWrEn),
        .rxWrIdx   (rxWrIdx),
        .rxWrData  (rxWrData),
        .rdIdx     (addr_r[6:0]),
        .rdData    (fbRdData),
        .frameLen  (frameLen)
    );

    // ----------------------------------------------------------------
    // Outgoing byte selection
    // ----------------------------------------------------------------
    reg  [7:0] echoByte;
    reg  [7:0] regRdData;
    reg  [7:0] txNext;

    // Status echo; a pending-flag view has no clearing side effect
    always @* begin
        case (trxCtrlOne_r[`SBAP_ECHO_HI:`SBAP_ECHO_LO])
            `SBAP_ECHO_ZERO:  echoByte = `SBAP_FILL;
            `SBAP_ECHO_STATE: echoByte = radioState;
            `SBAP_ECHO_RSSI:  echoByte = signalStrength;
            `SBAP_ECHO_IRQ:   echoByte = irqPending;
            default:          echoByte = `SBAP_FILL;
        endcase
    end

    // Register read mux; unmapped addresses read the fill value
    always @* begin
        case (regAddr_r)
            `SBAP_REG_STATE: regRdData = radioState;
            `SBAP_REG_CTRL1: regRdData = trxCtrlOne_r;
            `SBAP_REG_RSSI:  regRdData = signalStrength;
            `SBAP_REG_IRQ:   regRdData = irqPending;
            default:         regRdData = `SBAP_FILL;
        endcase
    end

    // Byte to shift out next; settles long before the next falling edge
    always @* begin
        txNext = `SBAP_FILL;
        case (state_r)
            `SBAP_ST_REGRD: begin
                txNext = regRdData;
            end
            `SBAP_ST_FBRD: begin
                if (addr_r <= lenByte) begin
                    txNext = fbRdData;
                end else begin
                    case (tailPos)
                        `SBAP_TAIL_LQI:  txNext = lqiValue;
                        `SBAP_TAIL_ED:   txNext = edValue;
                        `SBAP_TAIL_STAT: txNext = rxStatus;
                        default:         txNext = `SBAP_FILL;
                    endcase
                end
            end
            `SBAP_ST_SRDAT: begin
                if (!sramWr_r && inFbuf(addr_r)) begin
                    txNext = fbRdData;
                end else if (!sramWr_r && inSec(addr_r)) begin
                    txNext = secRdData;
                end
            end
            default: begin
                txNext = `SBAP_FILL;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Serial engine
    // ----------------------------------------------------------------
    // Bytes are decoded on the eighth rising edge, so the reply is
    // ready before the falling edge that starts the next byte.
    always @(posedge clk) begin
        if (rst) begin
            state_r              <= `SBAP_ST_IDLE;
            bitCnt_r             <= `SBAP_BIT_FIRST;
            rxSh_r               <= 7'h00;
            txSh_r               <= `SBAP_FILL;
            miso_r               <= 1'b0;
            misoOe_r             <= 1'b0;
            regAddr_r            <= 6'h00;
            addr_r               <= 8'h00;
            sramWr_r             <= 1'b0;
            spiWrEn_r            <= 1'b0;
            spiWrIdx_r           <= 7'h00;
            spiWrData_r          <= 8'h00;
            secWrEn_r            <= 1'b0;
            secWrData_r          <= 8'h00;
            secAddr_r            <= 8'h00;
            trxCtrlOne_r         <= `SBAP_CTRL1_RST;
            bufferViolationIrq_r <= 1'b0;
        end else begin
            spiWrEn_r            <= 1'b0;
            secWrEn_r            <= 1'b0;
            bufferViolationIrq_r <= 1'b0;
            secAddr_r            <= addr_r;
            if (selStart) begin
                // New transfer: status echo goes out first
                state_r  <= `SBAP_ST_CMD;
                bitCnt_r <= `SBAP_BIT_FIRST;
                txSh_r   <= echoByte;
                miso_r   <= echoByte[7];
                misoOe_r <= 1'b1;
                addr_r   <= 8'h00;
            end else if (!selAct) begin
                // Abort anywhere returns to idle; bytes already stored stay
                state_r  <= `SBAP_ST_IDLE;
                bitCnt_r <= `SBAP_BIT_FIRST;
                misoOe_r <= 1'b0;
                miso_r   <= 1'b0;
            end else begin
                if (sclkFall) begin
                    if (bitCnt_r == `SBAP_BIT_FIRST) begin
                        txSh_r <= txNext;
                        miso_r <= txNext[7];
                    end else begin
                        txSh_r <= {txSh_r[6:0], 1'b0};
                        miso_r <= txSh_r[6];
                    end
                end
                if (sclkRise) begin
                    rxSh_r   <= rxByte[6:0];
                    bitCnt_r <= bitCnt_r + 3'h1;
                    if (bitCnt_r == `SBAP_BIT_LAST) begin
                        case (state_r)
                            `SBAP_ST_CMD: begin
                                addr_r <= 8'h00;
                                if (rxByte[`SBAP_CMD_REG_BIT]) begin
                                    regAddr_r <= rxByte[5:0];
                                    state_r   <= rxByte[`SBAP_CMD_WR_BIT] ?
                                                 `SBAP_ST_REGWR : `SBAP_ST_REGRD;
                                end else begin
                                    case (rxByte[`SBAP_CMD_MODE_HI:`SBAP_CMD_MODE_LO])
                                        `SBAP_CMD_FB_RD: state_r <= `SBAP_ST_FBRD;
                                        `SBAP_CMD_FB_WR: state_r <= `SBAP_ST_FBWR;
                                        default: begin
                                            state_r  <= `SBAP_ST_SRADR;
                                            sramWr_r <= rxByte[`SBAP_CMD_WR_BIT];
                                        end
                                    endcase
                                end
                            end
                            `SBAP_ST_REGWR: begin
                                if (regAddr_r == `SBAP_REG_CTRL1) begin
                                    trxCtrlOne_r <= rxByte;
                                end
                                state_r <= `SBAP_ST_IDLE;
                            end
                            `SBAP_ST_REGRD: begin
                                state_r <= `SBAP_ST_IDLE;
                            end
                            `SBAP_ST_FBRD: begin
                                if (addr_r > tailEnd) begin
                                    bufferViolationIrq_r <= 1'b1;
                                end else begin
                                    addr_r <= addr_r + 8'h01;
                                end
                            end
                            `SBAP_ST_FBWR: begin
                                if (addr_r > `SBAP_FBUF_LAST) begin
                                    bufferViolationIrq_r <= 1'b1;
                                end else begin
                                    spiWrEn_r   <= 1'b1;
                                    spiWrIdx_r  <= addr_r[6:0];
                                    spiWrData_r <= rxByte;
                                    addr_r      <= addr_r + 8'h01;
                                end
                            end
                            `SBAP_ST_SRADR: begin
                                addr_r  <= rxByte;
                                state_r <= `SBAP_ST_SRDAT;
                            end
                            `SBAP_ST_SRDAT: begin
                                // Out-of-window bytes are dropped silently
                                if (sramWr_r && inFbuf(addr_r)) begin
                                    spiWrEn_r   <= 1'b1;
                                    spiWrIdx_r  <= addr_r[6:0];
                                    spiWrData_r <= rxByte;
                                end
                                if (sramWr_r && inSec(addr_r)) begin
                                    secWrEn_r   <= 1'b1;
                                    secWrData_r <= rxByte;
                                end
                                addr_r <= addr_r + 8'h01;
                            end
                            default: begin
                                state_r <= state_r;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // SRAM mode never touches bufferViolationIrq_r
    // Length readable via SRAM address zero: left to host

endmodule

//--- tb/sbap_core_monitor.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the serial access core
// ------------------------------------------------------------
module sbap_core_monitor (
    // System
    input wire       clk,
    input wire       rst,
    // Serial pins
    input wire       sclk,
    input wire       selN,
    input wire       miso_r,
    input wire       misoOe_r,
    // Radio status
    input wire [7:0] radioState,
    input wire [7:0] signalStrength,
    input wire [7:0] irqPending,
    // Events and control
    input wire [7:0] secAddr_r,
    input wire       secWrEn_r,
    input wire [7:0] trxCtrlOne_r,
    input wire       bufferViolationIrq_r
);
    // First bit of the echo byte for the current echo setting
    wire [1:0] echoSel = trxCtrlOne_r[3:2];
    wire       echoMsb = (echoSel == 2'h1) ? radioState[7] :
                         (echoSel == 2'h2) ? signalStrength[7] :
                         (echoSel == 2'h3) ? irqPending[7] : 1'b0;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_oe_released: assert property (selN [*5] |-> !misoOe_r)
        else $error("MISO driver left on after deselect");
    a_oe_driven: assert property (!selN [*5] |-> misoOe_r)
        else $error("MISO driver off while selected");
    a_echo_msb: assert property ($rose(misoOe_r) |-> miso_r == echoMsb)
        else $error("First echo bit does not match echo setting");
    a_miso_rise_hold: assert property ($rose(sclk) |=> $stable(miso_r) [*8])
        else $error("MISO moved after a rising serial clock");
    a_miso_on_fall: assert property ($changed(miso_r) && $past(misoOe_r) |-> !$past(sclk, 2))
        else $error("MISO moved while serial clock high");
    a_ctrl_in_xfer: assert property ($changed(trxCtrlOne_r) |-> $past(misoOe_r))
        else $error("Control register changed outside a transfer");
    a_sec_wr_space: assert property (secWrEn_r |-> secAddr_r >= 8'h82 && secAddr_r <= 8'h94
        && misoOe_r ##1 !secWrEn_r)
        else $error("Security write outside its space or too long");
    a_irq_pulse: assert property (bufferViolationIrq_r |-> misoOe_r ##1 !bufferViolationIrq_r)
        else $error("Violation pulse outside transfer or too long");
endmodule

//--- tb/sbap_spi_host.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Serial master model, mode 0, link clock 160 ns
// ------------------------------------------------------------
module sbap_spi_host (
    // Framing reference
    input  wire logic clk,
    // Serial pins
    output logic      sclk,
    output logic      selN,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] txBuf [0:15];
    logic [7:0] rxBuf [0:15];

    // Clock stands still low between frames
    initial begin
        sclk = 1'b0;
        selN = 1'b1;
        mosi = 1'b0;
    end

    // One framed transfer of n bytes; every pin change lands on a falling clk edge
    task automatic frame(input int n);
        @(negedge clk);
        selN = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = txBuf[i][b];
                #80 sclk = 1'b1;
                rxBuf[i][b] = miso;
                #80 sclk = 1'b0;
            end
        end
        #40;
        @(negedge clk);
        selN = 1'b1;
        mosi = ~mosi; // Released line must not keep a stale level
        repeat (8) @(negedge clk);
    endtask
endmodule

//--- tb/sbap_core_tb_top.sv
`timescale 1ns/100ps
module sbap_core_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    wire        sclk, selN, mosi, miso_r, misoOe_r, secWrEn_r, violIrq;
    wire  [7:0] secAddr_r, secWrData_r, trxCtrlOne_r;
    logic [7:0] radioState = 8'h96, signalStrength = 8'h4B, irqPending = 8'hC8;
    logic [7:0] lqiValue = 8'h77, edValue = 8'h3E, rxStatus = 8'hA5;
    logic       rxWrEn = 1'b0;
    logic [6:0] rxWrIdx = 7'h00;
    logic [7:0] rxWrData = 8'h00;
    logic [7:0] secA, secD;
    int         n_fail = 0, num_checks = 0, nIrq = 0, nSec = 0, k;
    // Security space answers with inverted address
    wire  [7:0] secRdData = secAddr_r ^ 8'hFF;
    // No pull on MISO, so an undriven line floats
    wire        misoLine = misoOe_r ? miso_r : 1'bz;

    always #2.5 clk = ~clk;

    // Event counters on design outputs
    always @(posedge clk) begin
        if (violIrq) nIrq++;
        if (secWrEn_r) begin
            nSec++;
            secA = secAddr_r;
            secD = secWrData_r;
        end
    end

    sbap_core i_dut (.clk(clk), .rst(rst), .sclk(sclk), .selN(selN), .mosi(mosi),
        .miso_r(miso_r), .misoOe_r(misoOe_r), .radioState(radioState),
        .signalStrength(signalStrength), .irqPending(irqPending), .lqiValue(lqiValue),
        .edValue(edValue), .rxStatus(rxStatus), .rxWrEn(rxWrEn), .rxWrIdx(rxWrIdx),
        .rxWrData(rxWrData), .secRdData(secRdData), .secAddr_r(secAddr_r),
        .secWrData_r(secWrData_r), .secWrEn_r(secWrEn_r), .trxCtrlOne_r(trxCtrlOne_r),
        .bufferViolationIrq_r(violIrq));
    sbap_spi_host i_host (.clk(clk), .sclk(sclk), .selN(selN), .mosi(mosi), .miso(misoLine));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xf(input logic [7:0] q[$]);
        foreach (q[i]) i_host.txBuf[i] = q[i];
        i_host.frame(q.size());
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("ctrl reset", trxCtrlOne_r, 8'h20);
        xf('{8'h84, 8'h00});
        check("echo after reset", i_host.rxBuf[0], 8'h00);
        check("ctrl read", i_host.rxBuf[1], 8'h20);
        xf('{8'h9F, 8'h00});
        check("unmapped read", i_host.rxBuf[1], 8'h00);
    endtask

    task automatic t_reg;
        xf('{8'hC4, 8'h2C, 8'hFF});
        check("ctrl write", trxCtrlOne_r, 8'h2C);
        xf('{8'h81, 8'h00});
        check("state read", i_host.rxBuf[1], radioState);
    endtask

    // Every echo setting, then echo of pending flags leaves them intact
    task automatic t_echo;
        logic [7:0] exp [0:3];
        exp = '{8'h00, radioState, signalStrength, irqPending};
        for (int m = 0; m < 4; m++) begin
            xf('{8'hC4, {4'h2, m[1:0], 2'h0}});
            xf('{8'h8F, 8'h00});
            check("echo byte", i_host.rxBuf[0], exp[m]);
            check("pending read", i_host.rxBuf[1], irqPending);
        end
        xf('{8'hC4, 8'h20});
    endtask

    task automatic t_frame;
        logic [7:0] exp [0:7];
        exp = '{8'h03, 8'hA1, 8'h5A, 8'hA3, lqiValue, edValue, rxStatus, 8'h00};
        xf('{8'h60, 8'h03, 8'hA1, 8'hA2, 8'hA3});
        @(negedge clk);
        rxWrEn = 1'b1;
        rxWrIdx = 7'h02;
        rxWrData = 8'h5A;
        @(negedge clk);
        rxWrEn = 1'b0;
        k = nIrq;
        xf('{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 8; i++) check("frame read", i_host.rxBuf[i + 1], exp[i]);
        check("overrun pulses", nIrq[7:0], k[7:0] + 8'h01);
        xf('{8'h20, 8'h00, 8'h00});
        xf('{8'h20, 8'h00});
        check("restart length", i_host.rxBuf[1], 8'h03);
    endtask

    task automatic t_sram;
        k = nIrq;
        xf('{8'h40, 8'h7E, 8'hB1, 8'hB2});
        xf('{8'h00, 8'h7E, 8'h00, 8'h00});
        check("sram data 0", i_host.rxBuf[2], 8'hB1);
        check("sram data 1", i_host.rxBuf[3], 8'hB2);
        xf('{8'h00, 8'h00, 8'h00});
        check("sram length", i_host.rxBuf[2], 8'h03);
        xf('{8'h40, 8'h90, 8'hC3});
        check("sec addr", secA, 8'h90);
        check("sec data", secD, 8'hC3);
        check("sec count", nSec[7:0], 8'h01);
        xf('{8'h00, 8'h91, 8'h00});
        check("sec read", i_host.rxBuf[2], 8'h6E);
        check("sram no pulse", nIrq[7:0], k[7:0]);
    endtask

    // Watchdog cuts a hang short; 80,000 clk keeps a hung run bounded
    initial begin
        #400us;
        n_fail++;
        close_out;
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset;
        t_reg;
        t_echo;
        t_frame;
        t_sram;
        close_out;
    end
endmodule

bind sbap_core sbap_core_monitor i_mon (.clk(clk), .rst(rst), .sclk(sclk), .selN(selN),
    .miso_r(miso_r), .misoOe_r(misoOe_r), .radioState(radioState),
    .signalStrength(signalStrength), .irqPending(irqPending), .secAddr_r(secAddr_r),
    .secWrEn_r(secWrEn_r), .trxCtrlOne_r(trxCtrlOne_r),
    .bufferViolationIrq_r(bufferViolationIrq_r));
